// *** sdcs_checker.sv ***
// sdcs_checker: port assertions of the conversion sequencer.
// assumes ce_i held high and a host that reads each word promptly.
`timescale 1ns/10ps
module sdcs_checker
	import sdcs_pkg::*;
#(
	parameter int unsigned OSC_CYC = 20,
	parameter int unsigned SETTLE_CYCLES = 300,
	parameter int unsigned PERIOD_CYC = 200
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	// watched pins
	input wire logic dout_rdy_o,
	input wire logic dout_rdy_oe_o,
	input wire logic power_down_reset_n_i
);
	logic [31:0] up_q;
	logic [7:0] hi_q;
	logic [15:0] per_q;
	logic seen_q;
	// a fall after a long high run marks a new result
	wire new_res = dout_rdy_oe_o && !dout_rdy_o && hi_q >= 8'd36;
	wire hi_now = dout_rdy_oe_o && dout_rdy_o;

	// cycles since power-up or pin release, high run, result spacing
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i || !power_down_reset_n_i) begin
			up_q <= 32'h0;
			seen_q <= 1'b0;
		end else begin
			up_q <= up_q + 32'h1;
			seen_q <= seen_q | new_res;
		end
		hi_q <= !hi_now ? 8'h0 : (hi_q == 8'hFF ? hi_q : hi_q + 8'h1);
		per_q <= new_res ? 16'h0 : per_q + 16'h1;
	end

	////////////////////////////////////////////////////////////////////////
	rst_float_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		$fell(sys_rst_i) |-> !dout_rdy_oe_o) else $error("line driven after reset");
	pin_float_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		!power_down_reset_n_i [*4] |-> !dout_rdy_oe_o) else $error("line driven in power-down");
	pin_clear_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		!power_down_reset_n_i [*4] |-> dout_rdy_o) else $error("result kept in power-down");
	oe_on_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		up_q == 32'd8 |-> dout_rdy_oe_o [*8]) else $error("line not driven after wake");
	hold_high_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		up_q >= 32'd8 && up_q < OSC_CYC + SETTLE_CYCLES |-> dout_rdy_o) else $error("early ready");
	first_res_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		up_q == OSC_CYC + SETTLE_CYCLES + 90 |-> seen_q) else $error("no first result");
	period_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		new_res && seen_q |-> per_q + 2 >= PERIOD_CYC && per_q <= PERIOD_CYC + 2) else $error("bad spacing");
	release_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		new_res |-> ##[1:210] dout_rdy_o) else $error("ready never withdrawn");
endmodule

bind sdcs_top sdcs_checker #(.OSC_CYC(OSC_CYC), .SETTLE_CYCLES(SETTLE_CYCLES), .PERIOD_CYC(PERIOD_CYC)) u_chk (
	.clk_sys_i(clk_sys_i),
	.sys_rst_i(sys_rst_i),
	.dout_rdy_o(dout_rdy_o),
	.dout_rdy_oe_o(dout_rdy_oe_o),
	.power_down_reset_n_i(power_down_reset_n_i)
);

// *** sdcs_divider.sv ***
// sdcs_divider: restoring divider, one quotient bit per enabled clock.
// assumes start is a one-cycle pulse and operands hold only at start.
`timescale 1ns/10ps

module sdcs_divider
	import sdcs_pkg::*;
(
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// request and answer
	sdcs_div_if.div dv
);

	logic [DIV_W-1:0] quo_q;
	logic [AIN_W:0] rem_q;
	logic [AIN_W-1:0] dsr_q;
	logic [BITCNT_W+1:0] cnt_q;
	logic busy_q;
	logic done_q;
	logic [AIN_W:0] rem_sh;
	logic [AIN_W:0] rem_sub;
	logic fits;

	////////////////////////////////////////////////////////////////////////
	// trial subtraction of the shifted remainder
	assign rem_sh = {rem_q[AIN_W-1:0], quo_q[DIV_W-1]};
	assign rem_sub = rem_sh - {1'b0, dsr_q};
	assign fits = rem_sh >= {1'b0, dsr_q};

	// iterate over every dividend bit
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			quo_q <= '0;
			rem_q <= '0;
			dsr_q <= '0;
			cnt_q <= '0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end else if (dv.en) begin
			done_q <= 1'b0;
			if (dv.start) begin
				quo_q <= dv.dividend;
				rem_q <= '0;
				dsr_q <= dv.divisor;
				cnt_q <= (BITCNT_W+2)'(DIV_W);
				busy_q <= 1'b1;
			end else if (busy_q) begin
				rem_q <= fits ? rem_sub : rem_sh;
				quo_q <= {quo_q[DIV_W-2:0], fits};
				cnt_q <= cnt_q - 1'b1;
				if (cnt_q == 1) begin
					busy_q <= 1'b0;
					done_q <= 1'b1;
				end
			end
		end
	end

	assign dv.done = done_q;
	assign dv.quotient = quo_q;

endmodule

// *** sdcs_host.sv ***
// sdcs_host: host side of the two-wire link, reads one word per call.
// assumes the caller starts a read only while the ready line is low.
`timescale 1ns/10ps
module sdcs_host (
	// serial link
	output logic sclk_o,
	input wire logic line_i
);
	// shift clock idles high between frames
	initial sclk_o = 1'b1;

	// one frame, msb first, sampled on the rising edge
	task automatic read_word(input int hp, output logic [23:0] w);
		#7;
		for (int i = 23; i >= 0; i--) begin
			#hp sclk_o = 1'b0;
			#hp sclk_o = 1'b1;
			w[i] = line_i;
		end
	endtask
endmodule

// *** sdcs_if.sv ***
// sdcs_if: carriers between the sequencer and its divider and serial link.
// assumes all signals of sdcs_div_if live on the system clock.
`timescale 1ns/10ps

// request and answer of the result divider
interface sdcs_div_if;
	import sdcs_pkg::*;
	logic en;
	logic start;
	logic [DIV_W-1:0] dividend;
	logic [AIN_W-1:0] divisor;
	logic done;
	logic [DIV_W-1:0] quotient;
	modport req (output en, output start, output dividend, output divisor, input done, input quotient);
	modport div (input en, input start, input dividend, input divisor, output done, output quotient);
endinterface

// word hand-over to the shift-clock domain
interface sdcs_ser_if;
	import sdcs_pkg::*;
	logic clr;
	logic [WORD_W-1:0] word;
	logic out_bit;
	logic read_done;
	modport seq (output clr, output word, input out_bit, input read_done);
	modport link (input clr, input word, output out_bit, output read_done);
endinterface

// *** sdcs_pkg.sv ***
// sdcs_pkg: constants, field layout and types of the conversion sequencer.
// assumes a 25 MHz system clock; long counts are overridable at the top.
package sdcs_pkg;

	////////////////////////////////////////////////////////////////////////
	// timing, all times in their printed unit
	localparam int unsigned CLK_PERIOD_NS = 40;
	localparam int unsigned OUT_RATE_HZ = 125;
	localparam int unsigned CONV_PERIOD_US = 8000;
	localparam int unsigned SETTLE_US = 24000;
	localparam int unsigned OSC_START_US = 1000;

	// cycle counts derived from the times, least times rounded up
	localparam int unsigned CONV_PERIOD_CYC = (CONV_PERIOD_US * 1000) / CLK_PERIOD_NS;
	localparam int unsigned SETTLE_CYC = (SETTLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned OSC_START_CYC = (OSC_START_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CNT_W = 24;

	////////////////////////////////////////////////////////////////////////
	// data widths
	localparam int unsigned AIN_W = 24;
	localparam int unsigned RES_W = 16;
	localparam int unsigned STAT_W = 8;
	localparam int unsigned WORD_W = 24;
	localparam int unsigned FRAC_SHIFT = 15;
	localparam int unsigned DIV_W = 40;
	localparam int unsigned BITCNT_W = 5;

	// result codes, offset binary
	localparam logic [RES_W-1:0] CODE_ZERO = 16'h8000;
	localparam logic [RES_W-1:0] CODE_POS_FS = 16'hFFFF;
	localparam logic [RES_W-1:0] CODE_NEG_FS = 16'h0000;

	// status byte fields: ready, zero, error, id[1:0], pattern[2:0]
	localparam int unsigned ST_RDY_POS = 7;
	localparam int unsigned ST_ZERO_POS = 6;
	localparam int unsigned ST_ERR_POS = 5;
	localparam int unsigned ST_ID_LSB = 3;
	localparam int unsigned ST_PAT_LSB = 0;
	localparam logic [2:0] TRANSFER_CHECK_PATTERN = 3'h5;
	// device id value is arbitrary
	localparam logic [1:0] DEV_ID_DEF = 2'h2;

	// reset values
	localparam logic [WORD_W-1:0] WORD_RST = 24'h000000;
	localparam logic [CNT_W-1:0] CNT_RST = 24'h000000;

	// sequencer phases
	typedef enum logic [1:0] {
		SEQ_OFF,
		SEQ_OSC_START,
		SEQ_CONVERT
	} sdcs_seq_t;

endpackage

// *** sdcs_serial_link.sv ***
// sdcs_serial_link: shifts the 24-bit word out on the shift clock.
// assumes the word is steady while ready is shown; clr is a flop output.
`timescale 1ns/10ps

module sdcs_serial_link
	import sdcs_pkg::*;
(
	// shift clock from the host
	input wire logic sclk_i,
	// word and status
	sdcs_ser_if.link sr
);

	logic [BITCNT_W-1:0] cnt_q;
	logic bit_q;
	logic done_q;
	logic [BITCNT_W-1:0] idx;

	////////////////////////////////////////////////////////////////////////
	// msb first: result, then status byte
	assign idx = BITCNT_W'(WORD_W - 1) - cnt_q;

	// advance on each falling edge until all 24 bits are out, cleared by the other domain
	always_ff @(negedge sclk_i or posedge sr.clr) begin
		if (sr.clr) begin
			cnt_q <= '0;
			bit_q <= 1'b0;
			done_q <= 1'b0;
		end else if (cnt_q != BITCNT_W'(WORD_W)) begin
			bit_q <= sr.word[idx];
			cnt_q <= cnt_q + 1'b1;
			done_q <= (cnt_q == BITCNT_W'(WORD_W - 1));
		end
	end

	assign sr.out_bit = bit_q;
	assign sr.read_done = done_q;

endmodule

// *** sdcs_top.sv ***
// sdcs_top: conversion sequencer of a single-channel 16-bit converter.
// assumes sys_rst_i is the power-on reset and the host clocks only while
// the ready line is low; analog levels arrive as held digital words.
//
// Overview of operation
// - convert continuously, one new result every 8 ms (125 Hz).
// - first result after any reset only after the full 24 ms settling.
// - every completed conversion goes to the result word, never flagged unsettled.
// - reset pin low stops converter and clock, ready line floats.
// - reset pin low clears control, filter, modulator and serial state.
// - after pin release wait about 1 ms, then start converting.
// - on leaving power-down drive ready line high until first result.
// - power-up performs the same internal reset as the pin.
// - offset binary: all zeros, top bit only, all ones at the extremes.
// - code equals 2^15 times one plus input over reference.
// - gain of one, full span is minus to plus reference.
// - each read shifts 24 bits: 16-bit result then eight status bits.
// - line returns high after read, or before the next update; once only.
// - status carries a fixed check pattern 101.
// - error bit set when the input was out of range.
`timescale 1ns/10ps

module sdcs_top
	import sdcs_pkg::*;
#(
	parameter int unsigned OSC_CYC = OSC_START_CYC,
	parameter int unsigned SETTLE_CYCLES = SETTLE_CYC,
	parameter int unsigned PERIOD_CYC = CONV_PERIOD_CYC,
	parameter logic [1:0] DEV_ID = DEV_ID_DEF
) (
	// system clock, reset and enable
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic ce_i,
	// serial link
	input wire logic sclk_i,
	output logic dout_rdy_o,
	output logic dout_rdy_oe_o,
	// power-down and reset pin
	input wire logic power_down_reset_n_i,
	// sampled analog levels
	input wire logic [AIN_W-1:0] positive_analog_input_i,
	input wire logic [AIN_W-1:0] negative_analog_input_i,
	input wire logic [AIN_W-1:0] reference_voltage_input_i
);

	sdcs_div_if dv ();
	sdcs_ser_if sr ();

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	logic pd_m_q;
	logic pd_s_q;
	logic rd_m_q;
	logic rd_s_q;
	logic [AIN_W-1:0] pos_m_q;
	logic [AIN_W-1:0] pos_s_q;
	logic [AIN_W-1:0] neg_m_q;
	logic [AIN_W-1:0] neg_s_q;
	logic [AIN_W-1:0] ref_m_q;
	logic [AIN_W-1:0] ref_s_q;

	// two flops on every foreign input
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			pd_m_q <= 1'b0;
			pd_s_q <= 1'b0;
			rd_m_q <= 1'b0;
			rd_s_q <= 1'b0;
		end else if (ce_i) begin
			pd_m_q <= power_down_reset_n_i;
			pd_s_q <= pd_m_q;
			rd_m_q <= sr.read_done;
			rd_s_q <= rd_m_q;
		end
	end

	// analog words, no reset needed on data path
	always_ff @(posedge clk_sys_i) begin
		if (ce_i) begin
			pos_m_q <= positive_analog_input_i;
			pos_s_q <= pos_m_q;
			neg_m_q <= negative_analog_input_i;
			neg_s_q <= neg_m_q;
			ref_m_q <= reference_voltage_input_i;
			ref_s_q <= ref_m_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// internal reset and sequencer

	logic rst_int;
	sdcs_seq_t seq_q;
	sdcs_seq_t seq_d;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic cnt_zero;
	logic conv_tick;

	// power-on and pin both reset sequencer, divider, flags and hand-over
	assign rst_int = sys_rst_i | ~pd_s_q;
	assign cnt_zero = (cnt_q == CNT_RST);
	assign conv_tick = (seq_q == SEQ_CONVERT) && cnt_zero;

	// phase and count selection
	always_comb begin
		seq_d = seq_q;
		cnt_d = cnt_q - 1'b1;
		case (seq_q)
			SEQ_OFF: begin
				seq_d = SEQ_OSC_START;
				cnt_d = CNT_W'(OSC_CYC - 1);
			end
			SEQ_OSC_START: begin
				if (cnt_zero) begin
					seq_d = SEQ_CONVERT;
					cnt_d = CNT_W'(SETTLE_CYCLES - 1);
				end
			end
			SEQ_CONVERT: begin
				if (cnt_zero) begin
					cnt_d = CNT_W'(PERIOD_CYC - 1);
				end
			end
			default: begin
				seq_d = SEQ_OFF;
				cnt_d = CNT_RST;
			end
		endcase
	end

	// oscillator held still while in reset
	always_ff @(posedge clk_sys_i) begin
		if (rst_int) begin
			seq_q <= SEQ_OFF;
			cnt_q <= CNT_RST;
		end else if (ce_i) begin
			seq_q <= seq_d;
			cnt_q <= cnt_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// input scaling and range check

	logic signed [AIN_W:0] vin;
	logic vin_neg;
	logic [AIN_W-1:0] vin_mag;
	logic over_rng;
	logic err_rng;

	// differential input and its magnitude
	assign vin = $signed({1'b0, pos_s_q}) - $signed({1'b0, neg_s_q});
	assign vin_neg = vin[AIN_W];
	assign vin_mag = vin_neg ? AIN_W'(-vin) : vin[AIN_W-1:0];
	assign over_rng = (vin_mag >= ref_s_q);
	assign err_rng = (vin_mag > ref_s_q) || (ref_s_q == '0);

	// divider takes magnitude scaled by 2^15 over reference
	assign dv.en = ce_i;
	assign dv.start = conv_tick;
	assign dv.dividend = DIV_W'({vin_mag, {FRAC_SHIFT{1'b0}}});
	assign dv.divisor = ref_s_q;

	sdcs_divider u_div (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_int),
		.dv(dv)
	);

	////////////////////////////////////////////////////////////////////////
	// result word

	logic neg_q;
	logic over_q;
	logic err_q;
	logic [RES_W-1:0] code;
	logic [STAT_W-1:0] status;

	// offset binary around mid code
	assign code = over_q ? (neg_q ? CODE_NEG_FS : CODE_POS_FS) :
		(neg_q ? CODE_ZERO - dv.quotient[RES_W-1:0] : CODE_ZERO + dv.quotient[RES_W-1:0]);

	// status: ready low, zero, error, id, check pattern
	always_comb begin
		status = '0;
		status[ST_RDY_POS] = 1'b0;
		status[ST_ZERO_POS] = 1'b0;
		status[ST_ERR_POS] = err_q;
		status[ST_ID_LSB +: 2] = DEV_ID;
		status[ST_PAT_LSB +: 3] = TRANSFER_CHECK_PATTERN;
	end

	// range flags captured with the sample
	always_ff @(posedge clk_sys_i) begin
		if (rst_int) begin
			neg_q <= 1'b0;
			over_q <= 1'b0;
			err_q <= 1'b0;
		end else if (ce_i && conv_tick) begin
			neg_q <= vin_neg;
			over_q <= over_rng;
			err_q <= err_rng;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// ready handshake and word hand-over

	logic [WORD_W-1:0] word_q;
	logic avail_q;
	logic clr_q;
	logic pub_q;
	logic oe_q;

	// drop ready, clear link, publish, then show ready
	always_ff @(posedge clk_sys_i) begin
		if (rst_int) begin
			word_q <= WORD_RST;
			avail_q <= 1'b0;
			clr_q <= 1'b1;
			pub_q <= 1'b0;
		end else if (ce_i) begin
			pub_q <= 1'b0;
			if (conv_tick) begin
				avail_q <= 1'b0;
				clr_q <= 1'b1;
			end else if (dv.done) begin
				word_q <= {code, status};
				clr_q <= 1'b0;
				pub_q <= 1'b1;
			end else if (pub_q) begin
				avail_q <= 1'b1;
			end else if (rd_s_q) begin
				avail_q <= 1'b0;
			end
		end
	end

	// drive the line whenever the pin is released and sys_rst_i is low
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			oe_q <= 1'b0;
		end else if (ce_i) begin
			oe_q <= pd_s_q;
		end
	end

	assign sr.clr = clr_q;
	assign sr.word = word_q;

	sdcs_serial_link u_link (
		.sclk_i(sclk_i),
		.sr(sr)
	);

	////////////////////////////////////////////////////////////////////////
	// pin outputs

	// high until a result waits, then low, then shifted bits
	assign dout_rdy_o = avail_q ? sr.out_bit : 1'b1;
	assign dout_rdy_oe_o = oe_q;

endmodule

// *** sdcs_top_tb.sv ***
// sdcs_top_tb: self-checking bench of the conversion sequencer.
// assumes shortened counts and a host model on the serial link.
`timescale 1ns/10ps
module sdcs_top_tb;
	import sdcs_pkg::*;
	localparam int OSC = 20;
	localparam int SET = 300;
	localparam int PER = 200;
	localparam logic [1:0] ID = 2'h1;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic pin_n = 1'b1;
	logic last_q = 1'b0;
	logic sclk;
	logic dout;
	logic oe;
	logic [AIN_W-1:0] pos = 24'h800000;
	logic [AIN_W-1:0] neg = 24'h800000;
	logic [AIN_W-1:0] vref = 24'h100000;
	int err_total = 0;
	int tests_run = 0;
	// released line shows the inverse of its last level
	wire line = oe ? dout : ~last_q;

	// clock and floating-line memory
	always #20 clk = ~clk;
	always @(posedge clk) begin
		if (oe) last_q <= dout;
	end

	sdcs_top #(.OSC_CYC(OSC), .SETTLE_CYCLES(SET), .PERIOD_CYC(PER), .DEV_ID(ID)) u_dut (
		.clk_sys_i(clk),
		.sys_rst_i(rst),
		.ce_i(1'b1),
		.sclk_i(sclk),
		.dout_rdy_o(dout),
		.dout_rdy_oe_o(oe),
		.power_down_reset_n_i(pin_n),
		.positive_analog_input_i(pos),
		.negative_analog_input_i(neg),
		.reference_voltage_input_i(vref)
	);
	sdcs_host u_host (
		.sclk_o(sclk),
		.line_i(line)
	);

	////////////////////////////////////////////////////////////////////////
	task automatic stop_test;
		$display("tests %0d bad %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// waits for ready low, n counts cycles waited
	task automatic get_word(output logic [23:0] w, output int n, input int hp);
		n = 0;
		while (!(oe === 1'b1 && line === 1'b0)) begin
			@(negedge clk);
			n++;
			if (n > 2000) begin
				err_total++;
				$display("BAD %0t no result", $time);
				stop_test();
			end
		end
		if (hp > 0) u_host.read_word(hp, w);
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_power_up;
		int n;
		logic [23:0] w;
		chk(oe, 1'b1, "line driven");
		chk(line, 1'b1, "high before result");
		get_word(w, n, 40);
		chk(32'(n > OSC + SET && n < OSC + SET + 100), 32'h1, "first result time");
		$display("t_power_up done");
	endtask

	task automatic t_codes;
		logic [47:0] tab [7] = '{48'h800000_8000_00, 48'h900000_FFFF_00, 48'h700000_0000_00,
			48'h880000_C000_00, 48'h7C0000_6000_00, 48'hA00000_FFFF_01, 48'h600000_0000_01};
		logic [23:0] w;
		int n;
		foreach (tab[i]) begin
			@(negedge clk);
			pos = tab[i][47:24];
			get_word(w, n, 40);
			get_word(w, n, 40);
			chk(w, {tab[i][23:8], 2'h0, tab[i][0], ID, 3'h5}, "result word");
		end
		$display("t_codes done");
	endtask

	task automatic t_once;
		int n;
		logic [23:0] w;
		get_word(w, n, 40);
		repeat (4) @(negedge clk);
		chk(line, 1'b1, "high after read");
		get_word(w, n, 0);
		n = 0;
		while (line === 1'b0 && n < 300) begin
			@(negedge clk);
			n++;
		end
		chk(32'(n < PER), 32'h1, "unread result withdrawn");
		$display("t_once done");
	endtask

	task automatic t_pin;
		int n;
		logic [23:0] w;
		get_word(w, n, 0);
		pin_n = 1'b0;
		repeat (4) @(negedge clk);
		chk(oe, 1'b0, "line floats");
		pin_n = 1'b1;
		get_word(w, n, 40);
		chk(32'(n > OSC + SET), 32'h1, "settling after pin reset");
		$display("t_pin done");
	endtask

	// main sequence
	initial begin
		repeat (8) @(negedge clk);
		rst = 1'b0;
		repeat (10) @(negedge clk);
		t_power_up();
		t_codes();
		t_once();
		t_pin();
		stop_test();
	end
endmodule
